// file: verilog/amrf_pkg.sv
/*
  Shared constants and types for the converter selection and result block.
  Assumes a 32-bit AXI4-Lite register bus and one 100 MHz system clock.
*/
package amrf_pkg;

  // Register byte offsets.
  localparam logic [4:0] OFS_SEL   = 5'h00;
  localparam logic [4:0] OFS_CTLA  = 5'h04;
  localparam logic [4:0] OFS_CTLB  = 5'h08;
  localparam logic [4:0] OFS_RESL  = 5'h0C;
  localparam logic [4:0] OFS_RESH  = 5'h10;

  // Field positions of input_and_reference_select.
  localparam int SEL_REF_HI  = 7;
  localparam int SEL_REF_MID = 6;
  localparam int SEL_ADJ     = 5;
  localparam int SEL_REF_LO  = 4;
  localparam int SEL_CHAN_HI = 3;

  // Field positions of converter_control_a and converter_control_b.
  localparam int CTLA_ENABLE = 7;
  localparam int CTLA_START  = 6;
  localparam int CTLA_DONE   = 4;
  localparam int CTLB_BIP    = 7;
  localparam int CTLB_IPR    = 5;

  // Reset values.
  localparam logic [7:0] SEL_RESET  = 8'h00;
  localparam logic [9:0] RES_RESET  = 10'h000;

  // Conversion lengths in converter clock cycles.
  localparam int CONV_NORMAL = 13;
  localparam int CONV_LONG   = 25;

  // Result code limits.
  localparam logic [9:0] CODE_ZERO = 10'h000;
  localparam logic [9:0] CODE_MAX  = 10'h3FF;

  // Channel and reference codes.
  localparam logic [3:0] CH_BANDGAP = 4'hC;
  localparam logic [3:0] CH_GROUND  = 4'hD;
  localparam logic [3:0] CH_NONE    = 4'hE;
  localparam logic [3:0] CH_TEMP    = 4'hF;
  localparam logic [2:0] REF_VCC      = 3'h0;
  localparam logic [2:0] REF_EXT      = 3'h1;
  localparam logic [2:0] REF_1V1      = 3'h2;
  localparam logic [2:0] REF_1V1_CAP  = 3'h3;
  localparam logic [2:0] REF_2V56     = 3'h6;
  localparam logic [2:0] REF_2V56_CAP = 3'h7;
  localparam logic [2:0] PIN_TEMP     = 3'h4;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    AMRF_IDLE = 2'b01,
    AMRF_RUN  = 2'b10
  } amrf_conv_t;

  // Analog routing and reference steering toward the converter core.
  typedef struct packed {
    logic       ref_vcc;
    logic       ref_ext_pin;
    logic       ref_int_1v1;
    logic       ref_int_2v56;
    logic       ref_pin_cap;
    logic       single_ended;
    logic       differential;
    logic       gain_20x;
    logic       offset_short;
    logic [2:0] pos_pin;
    logic [2:0] neg_pin;
    logic       bandgap_in;
    logic       ground_in;
    logic       temp_enable;
    logic       no_input;
  } amrf_route_t;

  typedef struct packed {
    logic        awvalid;
    logic [4:0]  awaddr;
    logic        wvalid;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bready;
    logic        arvalid;
    logic [4:0]  araddr;
    logic        rready;
  } amrf_axil_req_t;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } amrf_axil_rsp_t;

endpackage

// file: verilog/amrf_decode.sv
/*
  Combinational decoder from the selection byte to analog routing.
  Assumes the caller registers the result before it leaves the block.
*/
`timescale 1ns/1ps
module amrf_decode
  import amrf_pkg::*;
(
  // Selection
  input  wire logic [7:0]           sel,
  // Routing
  output amrf_pkg::amrf_route_t     route
);

  logic [2:0] ref_f;
  logic [3:0] chan;

  always_comb
  begin
    ref_f = {sel[SEL_REF_HI], sel[SEL_REF_MID], sel[SEL_REF_LO]};
    chan  = sel[SEL_CHAN_HI:0];
    route = '0;
    // Codes 100 and 101 leave every reference switch open.
    route.ref_vcc      = (ref_f == REF_VCC);
    route.ref_ext_pin  = (ref_f == REF_EXT);
    route.ref_int_1v1  = (ref_f == REF_1V1) || (ref_f == REF_1V1_CAP);
    route.ref_int_2v56 = (ref_f == REF_2V56) || (ref_f == REF_2V56_CAP);
    route.ref_pin_cap  = (ref_f == REF_1V1_CAP) || (ref_f == REF_2V56_CAP);
    if (chan[3:2] == 2'b00)
    begin
      route.single_ended = 1'b1;
      route.pos_pin      = {1'b0, chan[1:0]};
    end
    else if (chan[3:2] != 2'b11)
    begin
      route.differential = 1'b1;
      route.gain_20x     = chan[0];
      route.pos_pin      = chan[3] ? 3'h0 : 3'h2;
      route.neg_pin      = {1'b0, ~chan[3], chan[1]};
      route.offset_short = ~chan[1];
    end
    else
    begin
      case (chan)
        CH_BANDGAP: route.bandgap_in = 1'b1;
        CH_GROUND:  route.ground_in  = 1'b1;
        CH_TEMP:
        begin
          route.single_ended = 1'b1;
          route.temp_enable  = 1'b1;
          route.pos_pin      = PIN_TEMP;
        end
        default:    route.no_input   = 1'b1;
      endcase
    end
  end

endmodule

// file: verilog/amrf_format.sv
/*
  Turns the core's signed sample into the stored 10-bit result code.
  Assumes the sample is the difference scaled by 1024 over the reference,
  gain already applied, in eleven-bit two's complement.
*/
`timescale 1ns/1ps
module amrf_format
  import amrf_pkg::*;
(
  // Sample and mode
  input  wire logic signed [10:0] sample,
  input  wire logic               differential,
  input  wire logic               bipolar,
  input  wire logic               reverse,
  // Code
  output logic [9:0]              code
);

  logic signed [11:0] val;
  logic signed [11:0] half;

  always_comb
  begin
    val  = (differential && reverse && !bipolar) ? -12'(sample)
                                                 : 12'(sample);
    half = val >>> 1;
    if (differential && bipolar)
    begin
      // Half scale keeps the sign in bit 9.
      if (half > 12'sd511)
        code = 10'h1FF;
      else if (half < -12'sd512)
        code = 10'h200;
      else
        code = half[9:0];
    end
    else if (val < 12'sd0)
      code = CODE_ZERO;
    else if (val > 12'sd1023)
      code = CODE_MAX;
    else
      code = val[9:0];
  end

endmodule

// file: verilog/amrf_top.sv
/*
  Converter selection, timing and result formatting behind AXI4-Lite.
  Assumes the analog core follows the routing outputs and presents a
  settled signed sample by the last cycle of each conversion.
*/
// Implementation choices: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module amrf_top
  import amrf_pkg::*;
#(
  parameter int CONV_NORMAL_CYC = CONV_NORMAL,
  parameter int CONV_LONG_CYC   = CONV_LONG
)
(
  // Clock and reset
  input  wire logic                  aclk,
  input  wire logic                  aresetn,
  // AXI4-Lite slave
  input  wire amrf_pkg::amrf_axil_req_t axil_req,
  output amrf_pkg::amrf_axil_rsp_t   axil_rsp,
  // Converter core
  input  wire logic signed [10:0]    core_sample,
  output amrf_pkg::amrf_route_t      core_route,
  output logic                       core_sample_start,
  output logic                       core_busy,
  output logic                       core_long_conv
);
  import amrf_pkg::*;

  if (CONV_NORMAL_CYC < 2 || CONV_LONG_CYC < CONV_NORMAL_CYC ||
      CONV_LONG_CYC > 255)
  begin : g_bad_len
    $error("conversion lengths out of range");
  end

  typedef struct packed {
    amrf_axil_rsp_t rsp;
    logic           aw_have;
    logic [4:0]     aw_addr;
    logic           w_have;
    logic [7:0]     w_data;
    logic           w_lane;
    logic [7:0]     sel;
    logic [7:0]     active_sel;
    logic           enable;
    logic           done;
    logic           bipolar;
    logic           reverse;
    logic           ref_pending;
    logic           long_next;
    logic           long_cur;
    amrf_conv_t     conv;
    logic [7:0]     cnt;
    logic [9:0]     result;
    logic           low_read_lock;
    amrf_route_t    route;
    logic           start_pulse;
  } amrf_state_t;

  amrf_state_t s_q;
  amrf_state_t s_d;
  amrf_route_t route_new;
  logic [9:0]  code_new;

  localparam logic [7:0] LEN_NORMAL = 8'(CONV_NORMAL_CYC);
  localparam logic [7:0] LEN_LONG   = 8'(CONV_LONG_CYC);

  // Result word as software sees it, adjusted by the live selection bit.
  function automatic logic [15:0] adjusted(input logic [9:0] res,
                                           input logic       left);
    adjusted = left ? {res, 6'h00} : {6'h00, res};
  endfunction

  function automatic logic mapped(input logic [4:0] a);
    mapped = (a == OFS_SEL) || (a == OFS_CTLA) || (a == OFS_CTLB) ||
             (a == OFS_RESL) || (a == OFS_RESH);
  endfunction

  amrf_decode u_decode (
    .sel   (s_q.sel),
    .route (route_new)
  );

  amrf_format u_format (
    .sample       (core_sample),
    .differential (s_q.route.differential),
    .bipolar      (s_q.bipolar),
    .reverse      (s_q.reverse),
    .code         (code_new)
  );

  always_comb
  begin
    logic        do_write;
    logic        do_read;
    logic        last_cyc;
    logic        start_req;
    logic        finish;
    logic [15:0] res_word;
    logic [7:0]  rd_byte;
    do_write  = 1'b0;
    do_read   = 1'b0;
    last_cyc  = 1'b0;
    start_req = 1'b0;
    finish    = 1'b0;
    res_word  = adjusted(s_q.result, s_q.sel[SEL_ADJ]);
    rd_byte   = 8'h00;
    s_d       = s_q;
    s_d.start_pulse = 1'b0;

    // Write channel: address and data are accepted in either order.
    if (axil_req.awvalid && s_q.rsp.awready)
    begin
      s_d.aw_have     = 1'b1;
      s_d.aw_addr     = axil_req.awaddr;
      s_d.rsp.awready = 1'b0;
    end
    if (axil_req.wvalid && s_q.rsp.wready)
    begin
      s_d.w_have     = 1'b1;
      s_d.w_data     = axil_req.wdata[7:0];
      s_d.w_lane     = axil_req.wstrb[0];
      s_d.rsp.wready = 1'b0;
    end
    if (s_q.aw_have && s_q.w_have && !s_q.rsp.bvalid)
    begin
      do_write       = s_q.w_lane;
      s_d.aw_have    = 1'b0;
      s_d.w_have     = 1'b0;
      s_d.rsp.bvalid = 1'b1;
      s_d.rsp.bresp  = mapped(s_q.aw_addr) ? RESP_OKAY : RESP_SLVERR;
    end
    if (s_q.rsp.bvalid && axil_req.bready)
    begin
      s_d.rsp.bvalid  = 1'b0;
      s_d.rsp.awready = 1'b1;
      s_d.rsp.wready  = 1'b1;
    end

    // Read channel.
    if (axil_req.arvalid && s_q.rsp.arready)
    begin
      do_read         = 1'b1;
      s_d.rsp.arready = 1'b0;
      s_d.rsp.rvalid  = 1'b1;
      s_d.rsp.rresp   = mapped(axil_req.araddr) ? RESP_OKAY : RESP_SLVERR;
      case (axil_req.araddr)
        OFS_SEL:  rd_byte = s_q.sel;
        OFS_CTLA:
        begin
          rd_byte[CTLA_ENABLE] = s_q.enable;
          rd_byte[CTLA_START]  = (s_q.conv == AMRF_RUN);
          rd_byte[CTLA_DONE]   = s_q.done;
        end
        OFS_CTLB:
        begin
          rd_byte[CTLB_BIP] = s_q.bipolar;
          rd_byte[CTLB_IPR] = s_q.reverse;
        end
        OFS_RESL:
        begin
          rd_byte           = res_word[7:0];
          s_d.low_read_lock = 1'b1;
        end
        OFS_RESH:
        begin
          rd_byte           = res_word[15:8];
          s_d.low_read_lock = 1'b0;
        end
        default:  rd_byte = 8'h00;
      endcase
      s_d.rsp.rdata = {24'h000000, rd_byte};
    end
    if (s_q.rsp.rvalid && axil_req.rready)
    begin
      s_d.rsp.rvalid  = 1'b0;
      s_d.rsp.arready = 1'b1;
    end

    // Register writes.
    if (do_write)
    begin
      case (s_q.aw_addr)
        OFS_SEL:  s_d.sel = s_q.w_data;
        OFS_CTLA:
        begin
          s_d.enable = s_q.w_data[CTLA_ENABLE];
          start_req  = s_q.w_data[CTLA_START] && s_q.w_data[CTLA_ENABLE];
          if (s_q.w_data[CTLA_DONE])
            s_d.done = 1'b0;
        end
        OFS_CTLB:
        begin
          s_d.bipolar = s_q.w_data[CTLB_BIP];
          s_d.reverse = s_q.w_data[CTLB_IPR];
        end
        default:  s_d.sel = s_q.sel;
      endcase
    end

    // Conversion sequencing.
    case (s_q.conv)
      AMRF_IDLE:
      begin
        if (start_req)
        begin
          s_d.conv        = AMRF_RUN;
          s_d.cnt         = s_q.long_next ? LEN_LONG : LEN_NORMAL;
          s_d.long_cur    = s_q.long_next;
          s_d.long_next   = 1'b0;
          s_d.start_pulse = 1'b1;
        end
      end
      AMRF_RUN:
      begin
        last_cyc = (s_q.cnt == 8'h01);
        if (!s_d.enable)
          s_d.conv = AMRF_IDLE;
        else if (last_cyc)
        begin
          finish   = 1'b1;
          s_d.conv = AMRF_IDLE;
        end
        else
          s_d.cnt = s_q.cnt - 8'h01;
      end
      default:  s_d.conv = AMRF_IDLE;
    endcase

    // Selection is locked while converting and tracks software otherwise.
    if (s_q.conv != AMRF_RUN || last_cyc)
    begin
      s_d.active_sel = s_q.sel;
      s_d.route      = route_new;
    end
    // A reference change arms a long conversion; it may land mid-run.
    if (s_q.sel[SEL_REF_HI:SEL_REF_MID] !=
          s_q.active_sel[SEL_REF_HI:SEL_REF_MID] ||
        s_q.sel[SEL_REF_LO] != s_q.active_sel[SEL_REF_LO])
      s_d.ref_pending = 1'b1;
    if (s_q.ref_pending && (s_q.conv != AMRF_RUN || last_cyc))
    begin
      s_d.ref_pending = 1'b0;
      s_d.long_next   = 1'b1;
    end

    // A finished result is dropped while a low byte read awaits its high.
    if (finish && !s_d.low_read_lock && !s_q.low_read_lock)
    begin
      s_d.result = code_new;
      s_d.done   = 1'b1;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_q             <= '0;
      s_q.rsp.awready <= 1'b1;
      s_q.rsp.wready  <= 1'b1;
      s_q.rsp.arready <= 1'b1;
      s_q.sel         <= SEL_RESET;
      s_q.active_sel  <= SEL_RESET;
      s_q.conv        <= AMRF_IDLE;
      s_q.result      <= RES_RESET;
      s_q.long_next   <= 1'b1;
    end
    else
      s_q <= s_d;
  end

  assign axil_rsp          = s_q.rsp;
  assign core_route        = s_q.route;
  assign core_sample_start = s_q.start_pulse;
  assign core_busy         = (s_q.conv == AMRF_RUN);
  assign core_long_conv    = s_q.long_cur;

endmodule

// file: dv/amrf_core_model.sv
/*
  Behavioural model of the analog pins and the sampling core.
  Assumes the bench sets pin levels in result steps at unity gain.
*/
`timescale 1ns/1ps
module amrf_core_model
  import amrf_pkg::*;
(
  // Converter side
  input  wire logic                  aclk,
  input  wire amrf_pkg::amrf_route_t route,
  input  wire logic                  busy,
  output logic signed [10:0]         sample
);
  int lvl [0:7];
  int v;

  initial
  begin
    sample = 11'sh000;
    lvl = '{default: 0};
  end

  // Outside a conversion the sample is not held, so it toggles.
  always @(posedge aclk)
    if (!busy)
      sample <= ~sample;
    else
    begin
      v = route.single_ended ? lvl[route.pos_pin]
        : lvl[route.pos_pin] - lvl[route.neg_pin];
      if (route.gain_20x)
        v = v * 20;
      if (route.offset_short || route.ground_in)
        v = 0;
      sample <= 11'(v);
    end
endmodule

// file: dv/amrf_top_props.sv
/*
  Checker for the converter selection block.
  Assumes it is bound to the top module and sees only its ports.
*/
`timescale 1ns/1ps
module amrf_top_props
  import amrf_pkg::*;
#(
  parameter int CONV_NORMAL_CYC = 13,
  parameter int CONV_LONG_CYC   = 25
)
(
  // Clock and reset
  input wire logic                     aclk,
  input wire logic                     aresetn,
  // Bus and core
  input wire amrf_pkg::amrf_axil_req_t axil_req,
  input wire amrf_pkg::amrf_axil_rsp_t axil_rsp,
  input wire logic signed [10:0]       core_sample,
  input wire amrf_pkg::amrf_route_t    core_route,
  input wire logic                     core_sample_start,
  input wire logic                     core_busy,
  input wire logic                     core_long_conv
);
  logic [7:0] cnt_q;
  logic [7:0] cnt_d;

  // Counts the busy cycles of a conversion, the start cycle included.
  always_comb
  begin
    cnt_d = cnt_q;
    if (core_sample_start)
      cnt_d = 8'h01;
    else if (core_busy)
      cnt_d = cnt_q + 8'h01;
  end

  always_ff @(posedge aclk)
    cnt_q <= aresetn ? cnt_d : 8'h00;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  property p_wr_answer;
    axil_req.awvalid && axil_rsp.awready && axil_req.wvalid
      && axil_rsp.wready |-> ##[1:2] axil_rsp.bvalid;
  endproperty
  a_wr_answer: assert property (p_wr_answer)
    else $error("write response missing");

  property p_rd_answer;
    axil_req.arvalid && axil_rsp.arready |=> axil_rsp.rvalid;
  endproperty
  a_rd_answer: assert property (p_rd_answer)
    else $error("read response missing");

  property p_rd_once;
    axil_rsp.rvalid && axil_req.rready |=> !axil_rsp.rvalid;
  endproperty
  a_rd_once: assert property (p_rd_once)
    else $error("read response repeated");

  property p_start_pulse;
    core_sample_start |-> core_busy ##1 !core_sample_start;
  endproperty
  a_start_pulse: assert property (p_start_pulse)
    else $error("start pulse malformed");

  property p_conv_len;
    $fell(core_busy) |-> cnt_q ==
      8'(core_long_conv ? CONV_LONG_CYC : CONV_NORMAL_CYC);
  endproperty
  a_conv_len: assert property (p_conv_len)
    else $error("conversion length wrong");

  // A margin of three cycles keeps clear of the last-cycle update.
  property p_route_frozen;
    core_busy && !core_sample_start && (cnt_q + 8'h03 < CONV_NORMAL_CYC)
      |=> $stable(core_route);
  endproperty
  a_route_frozen: assert property (p_route_frozen)
    else $error("routing changed mid conversion");

  property p_temp;
    core_route.temp_enable |-> core_route.single_ended
      && core_route.pos_pin == PIN_TEMP;
  endproperty
  a_temp: assert property (p_temp)
    else $error("temperature routing wrong");

  property p_gain;
    core_route.gain_20x |-> core_route.differential;
  endproperty
  a_gain: assert property (p_gain)
    else $error("gain without differential");

  property p_short;
    core_route.offset_short |-> core_route.differential
      && core_route.pos_pin == core_route.neg_pin;
  endproperty
  a_short: assert property (p_short)
    else $error("offset short on distinct pins");

  property p_ref_one;
    $onehot0({core_route.ref_vcc, core_route.ref_ext_pin,
      core_route.ref_int_1v1, core_route.ref_int_2v56});
  endproperty
  a_ref_one: assert property (p_ref_one)
    else $error("several references selected");

  cover property ($fell(core_busy) && core_long_conv);
  cover property (core_route.gain_20x && core_busy);
  cover property (axil_rsp.rvalid && axil_rsp.rresp == RESP_SLVERR);
endmodule

bind amrf_top amrf_top_props #(
  .CONV_NORMAL_CYC (CONV_NORMAL_CYC),
  .CONV_LONG_CYC   (CONV_LONG_CYC)
) i_props (
  .aclk              (aclk),
  .aresetn           (aresetn),
  .axil_req          (axil_req),
  .axil_rsp          (axil_rsp),
  .core_sample       (core_sample),
  .core_route        (core_route),
  .core_sample_start (core_sample_start),
  .core_busy         (core_busy),
  .core_long_conv    (core_long_conv)
);

// file: dv/adc_mux_ref_result_format_test.sv
/*
  Self-checking bench for the converter selection block.
  Assumes the core model and the bound checker are compiled with it.
*/
`timescale 1ns/1ps
module adc_mux_ref_result_format_test
  import amrf_pkg::*;
  ;
  logic               aclk;
  logic               aresetn;
  amrf_axil_req_t     req;
  amrf_axil_rsp_t     rsp;
  logic signed [10:0] smp;
  amrf_route_t        rt;
  logic               start;
  logic               busy;
  logic               lng;
  int                 n_fail;
  int                 check_count;
  logic [7:0]         d;
  logic [7:0]         dl;
  logic [1:0]         r;
  logic [3:0]         c;
  logic [2:0]         p;
  logic [4:0]         ref_exp [0:7];

  amrf_top i_dut (
    .aclk              (aclk),
    .aresetn           (aresetn),
    .axil_req          (req),
    .axil_rsp          (rsp),
    .core_sample       (smp),
    .core_route        (rt),
    .core_sample_start (start),
    .core_busy         (busy),
    .core_long_conv    (lng)
  );

  amrf_core_model i_core (
    .aclk   (aclk),
    .route  (rt),
    .busy   (busy),
    .sample (smp)
  );

  task automatic chk(input logic [15:0] got, input logic [15:0] e);
    check_count++;
    if (got !== e)
    begin
      n_fail++;
      $display("MISMATCH %0t got %h expected %h", $time, got, e);
    end
  endtask

  task automatic wr(input logic [4:0] a, input logic [7:0] v);
    req.awvalid <= 1'b1;
    req.awaddr  <= a;
    req.wvalid  <= 1'b1;
    req.wdata   <= {24'h000000, v};
    do
    begin
      @(posedge aclk);
      if (rsp.awready)
        req.awvalid <= 1'b0;
      if (rsp.wready)
        req.wvalid <= 1'b0;
    end while (rsp.bvalid !== 1'b1);
  endtask

  task automatic rd(input logic [4:0] a);
    req.arvalid <= 1'b1;
    req.araddr  <= a;
    do
    begin
      @(posedge aclk);
      if (rsp.arready)
        req.arvalid <= 1'b0;
    end while (rsp.rvalid !== 1'b1);
    d = rsp.rdata[7:0];
    r = rsp.rresp;
  endtask

  task automatic res(input logic [15:0] e);
    rd(OFS_RESL);
    dl = d;
    rd(OFS_RESH);
    chk({d, dl}, e);
  endtask

  // Polling is bounded to 60 reads; a missing done flag fails the done check that follows.
  task automatic go;
    int n;
    n = 0;
    wr(OFS_CTLA, 8'hD0);
    do
    begin
      rd(OFS_CTLA);
      n++;
    end while (d[CTLA_DONE] !== 1'b1 && n < 60);
    chk(d[CTLA_DONE], 1'b1);
  endtask

  task automatic conv(input logic [7:0] sel);
    wr(OFS_SEL, sel);
    go();
  endtask

  task automatic tally_and_finish;
    if (n_fail == 0 && check_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  initial
  begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  initial
  begin
    #300000;
    n_fail++;
    tally_and_finish();
  end

  initial
  begin
    n_fail = 0;
    check_count = 0;
    ref_exp = '{5'h10, 5'h08, 5'h04, 5'h05, 5'h00, 5'h00, 5'h02, 5'h03};
    req = '0;
    req.wstrb = 4'hF;
    req.bready = 1'b1;
    req.rready = 1'b1;
    aresetn = 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rd(OFS_SEL);
    chk(d, SEL_RESET);
    rd(OFS_CTLB);
    chk(d, 8'h00);
    rd(5'h14);
    chk(r, RESP_SLVERR);
    for (int i = 0; i < 8; i++)
      begin
        p = 3'(i);
        wr(OFS_SEL, {p[2:1], 1'b0, p[0], 4'h0});
        repeat (2) @(posedge aclk);
        chk({rt.ref_vcc, rt.ref_ext_pin, rt.ref_int_1v1, rt.ref_int_2v56,
          rt.ref_pin_cap}, ref_exp[i]);
      end
    for (int i = 0; i < 16; i++)
    begin
      c = 4'(i);
      p = c[3] ? 3'h0 : 3'h2;
      wr(OFS_SEL, {4'h0, c});
      repeat (2) @(posedge aclk);
      if (c < 4'hC)
        chk({rt.single_ended, rt.differential,
          rt.gain_20x, rt.offset_short, rt.pos_pin, rt.neg_pin},
          (c < 4'h4) ? {4'h8, c[2:0], 3'h0}
          : {3'b010 | {2'b00, c[0]}, !c[1], p, p + {2'b00, c[1]}});
      else
        chk({rt.differential, rt.bandgap_in, rt.ground_in, rt.no_input,
          rt.temp_enable, rt.single_ended},
          {1'b0, c == 4'hC, c == 4'hD, c == 4'hE, c == 4'hF, c == 4'hF});
    end
    i_core.lvl[1] = 341;
    conv(8'h01);
    chk(lng, 1'b1);
    res(16'h0155);
    i_core.lvl[1] = 1023;
    conv(8'h01);
    chk(lng, 1'b0);
    res(16'h03FF);
    i_core.lvl[2] = 300;
    i_core.lvl[3] = 100;
    conv(8'h06);
    res(16'h00C8);
    i_core.lvl[2] = 100;
    i_core.lvl[3] = 300;
    conv(8'h06);
    res(16'h0000);
    i_core.lvl[2] = 110;
    i_core.lvl[3] = 100;
    conv(8'h07);
    res(16'h00C8);
    wr(OFS_CTLB, 8'h80);
    i_core.lvl[2] = 100;
    i_core.lvl[3] = 300;
    conv(8'h06);
    res(16'h039C);
    i_core.lvl[2] = 300;
    i_core.lvl[3] = 100;
    conv(8'h06);
    res(16'h0064);
    wr(OFS_SEL, 8'h26);
    res(16'h1900);
    wr(OFS_CTLB, 8'h00);
    i_core.lvl[0] = 170;
    wr(OFS_SEL, 8'h00);
    wr(OFS_CTLA, 8'hD0);
    wr(OFS_SEL, 8'h01);
    go();
    res(16'h00AA);
    i_core.lvl[4] = 314;
    // The sensor is only read against the 1.1V reference.
    conv(8'h4F);
    chk(lng, 1'b1);
    res(16'h013A);
    rd(OFS_RESL);
    i_core.lvl[4] = 5;
    wr(OFS_CTLA, 8'hD0);
    repeat (CONV_LONG) @(posedge aclk);
    rd(OFS_CTLA);
    chk(d[CTLA_DONE], 1'b0);
    rd(OFS_RESH);
    chk(d, 8'h01);
    conv(8'h4F);
    res(16'h0005);
    tally_and_finish();
  end
endmodule
